// *** hdl/gf_lane_mult.sv ***
// one finite-field multiply lane for fields up to eight bits
module gf_lane_mult
  import mul_ctrl_pkg::*;
(
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire gf_cfg_t cfg,
  output logic [7:0] product
);
  always_comb begin
    logic [7:0] acc;
    logic [7:0] sh;
    logic [7:0] top;
    logic [7:0] msk;
    acc = 8'h00;
    sh = a;
    top = 8'h01 << cfg.size_m1;
    msk = (top << 1) - 8'h01;
    for (int i = 0; i < 8; i++) begin
      // operand bits above the field size take no part in the product
      if (b[i] && i <= int'(cfg.size_m1)) begin
        acc = acc ^ (sh & msk);
      end
      // shift-and-reduce: the dropped top coefficient is folded back by the generator
      if ((sh & top) != 8'h00) begin
        sh = ((sh << 1) ^ cfg.generator_coeffs) & msk;
      end else begin
        sh = (sh << 1) & msk;
      end
    end
    product = acc;
  end
endmodule : gf_lane_mult

// *** hdl/mul_ctrl_pkg.sv ***
// package: register layouts, reset values and carrier types for the multiplier control registers
package mul_ctrl_pkg;
  localparam logic [4:0] crsel_fp = 5'h00;
  localparam logic [4:0] crsel_gf = 5'h01;
  localparam logic [31:0] fp_reset = 32'h0000_0000;
  localparam logic [31:0] fp_write_mask = 32'h07ff_07ff;
  localparam int unsigned fp_unit_b_lsb = 16;
  localparam int unsigned fp_unit_a_lsb = 0;
  localparam int unsigned fp_rmode_lsb = 9;
  localparam int unsigned gf_size_lsb = 24;
  localparam int unsigned gf_generator_coeffs_lsb = 0;
  localparam logic [2:0] gf_size_reset = 3'h7;
  localparam logic [7:0] gf_generator_coeffs_reset = 8'h1d;
  localparam int unsigned gf_lanes = 4;

  typedef enum logic [1:0] {
    round_nearest = 2'h0,
    round_zero = 2'h1,
    round_pos_inf = 2'h2,
    round_neg_inf = 2'h3
  } round_mode_t;

  // sticky flags of one unit in bit order 8..0
  typedef struct packed {
    logic underflow_flag;
    logic rounded_result_flag;
    logic overflow_flag;
    logic infinity_result_flag;
    logic bad_operation_flag;
    logic src2_subnormal_flag;
    logic src1_subnormal_flag;
    logic src2_not_number_flag;
    logic src1_not_number_flag;
  } fp_flags_t;

  typedef struct packed {
    round_mode_t rmode;
    fp_flags_t flags;
  } fp_half_t;

  // event report from one multiplier unit at retire
  typedef struct packed {
    logic valid;
    logic cond_true;
    fp_flags_t flags;
  } fp_event_t;

  typedef struct packed {
    logic [2:0] size_m1;
    logic [7:0] generator_coeffs;
  } gf_cfg_t;

  typedef struct packed {
    logic we;
    logic [4:0] sel;
    logic [31:0] wdata;
  } ctrl_write_t;
endpackage : mul_ctrl_pkg

// *** hdl/mul_unit_ctrl.sv ***
// multiplier control registers with flag capture and the quad finite-field multiply
module mul_unit_ctrl
  import mul_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire ctrl_write_t ctrl_reg_move,
  input wire logic [4:0] rd_sel,
  input wire fp_event_t evt_unit_a,
  input wire fp_event_t evt_unit_b,
  input wire logic gf_mult_quad,
  input wire logic [31:0] gf_src1,
  input wire logic [31:0] gf_src2,
  output logic [31:0] rd_data,
  output logic [31:0] gf_result,
  output logic gf_result_valid,
  output round_mode_t rmode_unit_a,
  output round_mode_t rmode_unit_b
);
  typedef struct packed {
    fp_half_t mul_unit_b;
    fp_half_t mul_unit_a;
    gf_cfg_t gf;
    logic [31:0] rd_data;
    logic [31:0] gf_result;
    logic gf_result_valid;
  } state_t;

  state_t st;
  state_t next_st;
  gf_cfg_t gf_live;
  logic [31:0] gf_prod;
  logic [31:0] fp_word;
  logic [31:0] gf_word;

  // a move is forwarded so a multiply in the same cycle already sees it
  always_comb begin
    gf_live = st.gf;
    if (ctrl_reg_move.we && ctrl_reg_move.sel == crsel_gf) begin
      gf_live.size_m1 = ctrl_reg_move.wdata[gf_size_lsb +: 3];
      gf_live.generator_coeffs = ctrl_reg_move.wdata[gf_generator_coeffs_lsb +: 8];
    end
  end

  genvar ln;
  generate
    for (ln = 0; ln < gf_lanes; ln++) begin : g_lane
      gf_lane_mult u_lane (
        .a(gf_src1[8*ln +: 8]),
        .b(gf_src2[8*ln +: 8]),
        .cfg(gf_live),
        .product(gf_prod[8*ln +: 8])
      );
    end
  endgenerate

  function automatic fp_half_t merge_half(input fp_half_t cur, input fp_event_t ev);
    fp_half_t r;
    fp_flags_t f;
    r = cur;
    f = ev.flags;
    if (f.bad_operation_flag) begin
      f.rounded_result_flag = 1'b0;
    end
    if (ev.valid && ev.cond_true) begin
      r.flags = cur.flags | f;
    end
    return r;
  endfunction : merge_half

  assign fp_word = {5'h00, st.mul_unit_b, 5'h00, st.mul_unit_a};
  assign gf_word = {5'h00, st.gf.size_m1, 16'h0000, st.gf.generator_coeffs};

  always_comb begin
    fp_half_t wa;
    fp_half_t wb;
    logic [31:0] wm;
    next_st = st;
    wm = ctrl_reg_move.wdata & fp_write_mask;
    wa = fp_half_t'(wm[fp_unit_a_lsb +: 11]);
    wb = fp_half_t'(wm[fp_unit_b_lsb +: 11]);
    if (ctrl_reg_move.we && ctrl_reg_move.sel == crsel_fp) begin
      next_st.mul_unit_a = wa;
      next_st.mul_unit_b = wb;
    end
    // unit events are merged after the move so a set wins over a clear
    next_st.mul_unit_a = merge_half(next_st.mul_unit_a, evt_unit_a);
    next_st.mul_unit_b = merge_half(next_st.mul_unit_b, evt_unit_b);
    next_st.gf = gf_live;
    unique case (rd_sel)
      crsel_fp: next_st.rd_data = fp_word;
      crsel_gf: next_st.rd_data = gf_word;
      default: next_st.rd_data = 32'h0000_0000;
    endcase
    next_st.gf_result_valid = gf_mult_quad;
    if (gf_mult_quad) begin
      next_st.gf_result = gf_prod;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.mul_unit_a <= fp_half_t'(fp_reset[10:0]);
      st.mul_unit_b <= fp_half_t'(fp_reset[26:16]);
      st.gf.size_m1 <= gf_size_reset;
      st.gf.generator_coeffs <= gf_generator_coeffs_reset;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign gf_result = st.gf_result;
  assign gf_result_valid = st.gf_result_valid;
  assign rmode_unit_a = st.mul_unit_a.rmode;
  assign rmode_unit_b = st.mul_unit_b.rmode;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  gf_rsv_zero_a: assert property (rd_data[31:27] == 5'h00 && (!$past(rd_sel == crsel_gf)
    || rd_data[23:8] == 16'h0000)) else $error("gf reserved bits nonzero");
  fp_rsv_zero_a: assert property (!$past(rd_sel == crsel_fp) || (rd_data[31:27] == 5'h00
    && rd_data[15:11] == 5'h00)) else $error("fp reserved bits nonzero");
  flag_set_a: assert property (evt_unit_a.valid && evt_unit_a.cond_true
    && evt_unit_a.flags.underflow_flag |=> st.mul_unit_a.flags.underflow_flag)
    else $error("underflow not captured");
  flag_set_b_a: assert property (evt_unit_b.valid && evt_unit_b.cond_true
    && evt_unit_b.flags.overflow_flag |=> st.mul_unit_b.flags.overflow_flag)
    else $error("overflow not captured");
  rounded_result_flag_bad_operation_flag_a: assert property (evt_unit_a.valid && evt_unit_a.cond_true
    && evt_unit_a.flags.bad_operation_flag && !st.mul_unit_a.flags.rounded_result_flag
    && !ctrl_reg_move.we |=> !st.mul_unit_a.flags.rounded_result_flag)
    else $error("inexact with invalid");
  cond_false_a: assert property (!evt_unit_a.cond_true && !ctrl_reg_move.we
    |=> $stable(st.mul_unit_a)) else $error("false condition changed flags");
  gf_fwd_a: assert property (ctrl_reg_move.we && ctrl_reg_move.sel == crsel_gf
    |=> st.gf.generator_coeffs == $past(ctrl_reg_move.wdata[7:0]))
    else $error("gf write lost");
  gf_stable_a: assert property (!(ctrl_reg_move.we && ctrl_reg_move.sel == crsel_gf)
    |=> $stable(st.gf)) else $error("gf changed without move");
  gf_one_a: assert property (gf_mult_quad && gf_src2 == 32'h0101_0101
    && gf_src1[7:0] == 8'h03 && gf_live.size_m1 != 3'h0
    |=> gf_result[7:0] == 8'h03) else $error("gf identity");

  move_gf_c: cover property (ctrl_reg_move.we && ctrl_reg_move.sel == crsel_gf ##1 gf_mult_quad);
  flag_clear_c: cover property (ctrl_reg_move.we && evt_unit_a.valid && evt_unit_a.cond_true);
  cond_false_c: cover property (evt_unit_b.valid && !evt_unit_b.cond_true);
endmodule : mul_unit_ctrl

// *** tb/mul_unit_ctrl_tb.sv ***
// self-checking bench for the multiplier control registers
module mul_unit_ctrl_tb
  import mul_ctrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, gf_mult_quad, fa, fb, ca, cb, gf_result_valid;
  ctrl_write_t mv;
  logic [4:0] rd_sel;
  fp_flags_t fla, flb, f;
  fp_event_t evt_a, evt_b;
  logic [31:0] s1, s2, rd_data, gf_result, seed, efp, d, h;
  round_mode_t rma, rmb;
  int err_count, compares;

  mul_unit_ctrl mul_unit_ctrl_inst (.core_clk(core_clk), .rstn(rstn), .ctrl_reg_move(mv),
    .rd_sel(rd_sel), .evt_unit_a(evt_a), .evt_unit_b(evt_b), .gf_mult_quad(gf_mult_quad),
    .gf_src1(s1), .gf_src2(s2), .rd_data(rd_data), .gf_result(gf_result),
    .gf_result_valid(gf_result_valid), .rmode_unit_a(rma), .rmode_unit_b(rmb));
  mul_unit_model mul_unit_model_inst_a (.fire(fa), .cond(ca), .flags(fla), .evt(evt_a));
  mul_unit_model mul_unit_model_inst_b (.fire(fb), .cond(cb), .flags(flb), .evt(evt_b));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // shift-and-add product, reduced by the generator with x^m implicit
  function automatic logic [7:0] gf_ref(logic [7:0] a, logic [7:0] b, logic [2:0] sz,
                                        logic [7:0] g);
    logic [8:0] x;
    logic [7:0] p;
    logic [7:0] m;
    m = 8'hff >> (3'h7 - sz);
    x = {1'b0, a & m};
    p = 8'h00;
    for (int i = 0; i <= int'(sz); i++) begin
      if (b[i]) p = p ^ x[7:0];
      x = x << 1;
      if (x[int'(sz) + 1]) x = {1'b0, (x[7:0] ^ g) & m};
    end
    return p & m;
  endfunction : gf_ref

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // every task starts and ends at a falling edge
  task automatic wr(logic [4:0] sel, logic [31:0] v);
    mv = {1'b1, sel, v};
    @(negedge core_clk);
    mv.we = 1'b0;
  endtask : wr

  task automatic rd(logic [4:0] sel, logic [31:0] exp);
    rd_sel = sel;
    @(negedge core_clk);
    chk(rd_data, exp);
  endtask : rd

  task automatic ev(logic ub, logic c, fp_flags_t fl);
    fa = !ub;
    fb = ub;
    ca = c;
    cb = c;
    fla = fl;
    flb = fl;
    @(negedge core_clk);
    fa = 1'b0;
    fb = 1'b0;
  endtask : ev

  task automatic mul(logic [31:0] cfg);
    logic [31:0] e;
    s1 = rnd();
    s2 = rnd();
    for (int i = 0; i < 4; i++) e[8*i+:8] = gf_ref(s1[8*i+:8], s2[8*i+:8], cfg[26:24], cfg[7:0]);
    gf_mult_quad = 1'b1;
    @(negedge core_clk);
    gf_mult_quad = 1'b0;
    chk({31'h0, gf_result_valid}, 32'h1);
    chk(gf_result, e);
  endtask : mul

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #(20 * 3000);
    err_count++;
    print_verdict();
  end

  initial begin
    {rstn, gf_mult_quad, fa, fb, ca, cb, rd_sel, s1, s2, fla, flb} = '0;
    mv = '0;
    seed = 32'had67;
    err_count = 0;
    compares = 0;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    rd(crsel_fp, fp_reset);
    rd(crsel_gf, {5'h0, gf_size_reset, 16'h0, gf_generator_coeffs_reset});
    rd(5'h02, 32'h0);
    mul(32'h0700_001d);
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      d[26:24] = i[2:0];
      wr(crsel_gf, d);
      mul(d);
      rd(crsel_gf, d & 32'h0700_00ff);
      d = rnd();
      wr(crsel_fp, d);
      efp = d & fp_write_mask;
      rd(crsel_fp, efp);
      chk({30'h0, rma}, {30'h0, d[10:9]});
      chk({30'h0, rmb}, {30'h0, d[26:25]});
      h = rnd();
      f = fp_flags_t'(h[8:0]);
      if (i == 3) f = 9'h090;
      ev(i[0], i[1], f);
      h = {23'h0, f & ~(f.bad_operation_flag ? 9'h080 : 9'h000)};
      if (i[1]) efp = efp | (i[0] ? h << 16 : h);
      rd(crsel_fp, efp);
    end
    print_verdict();
  end
endmodule : mul_unit_ctrl_tb

// *** tb/mul_unit_model.sv ***
// model of one multiplier unit reporting its flags at retire
module mul_unit_model
  import mul_ctrl_pkg::*;
(
  input wire logic fire,
  input wire logic cond,
  input wire fp_flags_t flags,
  output fp_event_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // outside an event the lines show no stale value
  assign evt = fire ? {1'b1, cond, flags} : {1'b0, ~cond, ~flags};
endmodule : mul_unit_model
